// [src/interrupt_vector_priority.sv]
`timescale 1ns/1ns
module interrupt_vector_priority (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic illegal_instr,
    input wire logic swi3,
    input wire logic hw_stack_ovf,
    input wire logic misaligned_access,
    input wire logic swi2,
    input wire logic swi1,
    input wire logic swi0,
    input wire logic dbg_step,
    input wire logic dbg_brkpt,
    input wire logic dbg_trace,
    input wire logic dbg_tx_empty,
    input wire logic dbg_rx_full,
    input wire logic ext_request_a,
    input wire logic ext_request_b,
    input wire logic low_voltage_detect,
    input wire logic clk_synth_req,
    input wire logic flash_access_err,
    input wire logic flash_cmd_done,
    input wire logic flash_buf_empty,
    input wire logic can_bus_off,
    input wire logic can_error,
    input wire logic can_wake_up,
    input wire logic can_msg_buf,
    input wire logic [5:0] gpio_req,
    input wire logic ssp1_rx_full,
    input wire logic ssp1_tx_empty,
    input wire logic ssp0_rx_full,
    input wire logic ssp0_tx_empty,
    input wire logic asp1_tx_empty,
    input wire logic asp1_tx_idle,
    input wire logic asp1_rx_err,
    input wire logic asp1_rx_full,
    input wire logic asp0_tx_empty,
    input wire logic asp0_tx_idle,
    input wire logic asp0_rx_err,
    input wire logic asp0_rx_full,
    input wire logic quad1_home_wdog,
    input wire logic quad1_index,
    input wire logic quad0_home_wdog,
    input wire logic quad0_index,
    input wire logic [15:0] timer_req,
    input wire logic converter_b_done,
    input wire logic [ivp_pkg::NUM_VEC-1:0][ivp_pkg::LVL_W-1:0] level_cfg,
    input wire logic [ivp_pkg::LVL_W-1:0] core_mask_level,
    input wire logic [ivp_pkg::PADDR_W-1:0] vector_table_base,
    output logic irq_valid_r,
    output logic [ivp_pkg::VEC_W-1:0] irq_vector_r,
    output logic [ivp_pkg::LVL_W-1:0] irq_level_r,
    output logic [ivp_pkg::PADDR_W-1:0] irq_addr_r
);
    import ivp_pkg::*;

    logic [1:0] pin_s1_r;
    logic [1:0] pin_s2_r;
    logic [1:0] pin_s1_nxt;
    logic [1:0] pin_s2_nxt;
    logic [NUM_VEC-1:0] req_raw;
    logic [NUM_VEC-1:0] req_eff;
    logic [NUM_VEC-1:0][LVL_W-1:0] lvl;
    logic found;
    logic [VEC_W-1:0] win_vec;
    logic [LVL_W-1:0] win_lvl;
    logic irq_valid_nxt;
    logic [VEC_W-1:0] irq_vector_nxt;
    logic [LVL_W-1:0] irq_level_nxt;
    logic [PADDR_W-1:0] irq_addr_nxt;

    // The two request pins come from outside and pass two flip-flops first.
    always_comb begin
        pin_s1_nxt = {ext_request_b, ext_request_a};
        pin_s2_nxt = pin_s1_r;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1_r <= 2'h0;
            pin_s2_r <= 2'h0;
        end else begin
            pin_s1_r <= pin_s1_nxt;
            pin_s2_r <= pin_s2_nxt;
        end
    end

    // Each source is placed on its own vector.
    always_comb begin
        req_raw = '0;
        req_raw[VEC_ILLEGAL] = illegal_instr;
        req_raw[VEC_SWI3] = swi3;
        req_raw[VEC_STACK_OVF] = hw_stack_ovf;
        req_raw[VEC_MISALIGN] = misaligned_access;
        req_raw[VEC_SWI2] = swi2;
        req_raw[VEC_SWI1] = swi1;
        req_raw[VEC_SWI0] = swi0;
        req_raw[VEC_DBG_STEP] = dbg_step;
        req_raw[VEC_DBG_BRKPT] = dbg_brkpt;
        req_raw[VEC_DBG_TRACE] = dbg_trace;
        req_raw[VEC_DBG_TX] = dbg_tx_empty;
        req_raw[VEC_DBG_RX] = dbg_rx_full;
        req_raw[VEC_EXT_A] = pin_s2_r[0];
        req_raw[VEC_EXT_B] = pin_s2_r[1];
        req_raw[VEC_LVD] = low_voltage_detect;
        req_raw[VEC_CLK_SYNTH] = clk_synth_req;
        req_raw[VEC_FLASH_ERR] = flash_access_err;
        req_raw[VEC_FLASH_DONE] = flash_cmd_done;
        req_raw[VEC_FLASH_EMPTY] = flash_buf_empty;
        req_raw[VEC_CAN_BUS_OFF] = can_bus_off;
        req_raw[VEC_CAN_ERR] = can_error;
        req_raw[VEC_CAN_WAKE] = can_wake_up;
        req_raw[VEC_CAN_MSG] = can_msg_buf;
        req_raw[VEC_GPIO_BASE +: 6] = gpio_req;
        req_raw[VEC_SSP1_RX] = ssp1_rx_full;
        req_raw[VEC_SSP1_TX] = ssp1_tx_empty;
        req_raw[VEC_SSP0_RX] = ssp0_rx_full;
        req_raw[VEC_SSP0_TX] = ssp0_tx_empty;
        // Async serial ports, with a gap at each receive side.
        req_raw[VEC_ASP1_BASE + ASP_TX_EMPTY] = asp1_tx_empty;
        req_raw[VEC_ASP1_BASE + ASP_TX_IDLE] = asp1_tx_idle;
        req_raw[VEC_ASP1_BASE + ASP_RX_ERR] = asp1_rx_err;
        req_raw[VEC_ASP1_BASE + ASP_RX_FULL] = asp1_rx_full;
        req_raw[VEC_ASP0_BASE + ASP_TX_EMPTY] = asp0_tx_empty;
        req_raw[VEC_ASP0_BASE + ASP_TX_IDLE] = asp0_tx_idle;
        req_raw[VEC_ASP0_BASE + ASP_RX_ERR] = asp0_rx_err;
        req_raw[VEC_ASP0_BASE + ASP_RX_FULL] = asp0_rx_full;
        req_raw[VEC_QUAD_DECODER_1_HOME] = quad1_home_wdog;
        req_raw[VEC_QUAD_DECODER_1_INDEX] = quad1_index;
        req_raw[VEC_QUAD_DECODER_0_HOME] = quad0_home_wdog;
        req_raw[VEC_QUAD_DECODER_0_INDEX] = quad0_index;
        req_raw[VEC_TIMER_BASE +: 16] = timer_req;
        req_raw[VEC_CONV_B] = converter_b_done;
    end

    // Levels are fixed or clamped per source, then gated by the core mask.
    always_comb begin
        for (int v = 0; v < NUM_VEC; v++) begin
            lvl[v] = resolve_level(v, level_cfg[v]);
            // Only levels at or above the mask count.
            req_eff[v] = req_raw[v] && vector_is_used(v) && (lvl[v] >= core_mask_level);
        end
    end

    vector_arbiter u_arbiter (
        .req(req_eff),
        .lvl(lvl),
        .found(found),
        .win_vec(win_vec),
        .win_lvl(win_lvl)
    );

    always_comb begin
        irq_valid_nxt = found;
        irq_vector_nxt = found ? win_vec : RST_VEC;
        irq_level_nxt = found ? win_lvl : RST_LVL;
        // Base plus two words per entry.
        irq_addr_nxt = found ? PADDR_W'(vector_table_base + entry_offset(win_vec)) : RST_ADDR;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_valid_r <= RST_VALID;
            irq_vector_r <= RST_VEC;
            irq_level_r <= RST_LVL;
            irq_addr_r <= RST_ADDR;
        end else begin
            irq_valid_r <= irq_valid_nxt;
            irq_vector_r <= irq_vector_nxt;
            irq_level_r <= irq_level_nxt;
            irq_addr_r <= irq_addr_nxt;
        end
    end

    // Checking helpers compute the expected winner a second way.
    logic hlp_any;
    logic [LVL_W-1:0] hlp_max;
    logic [VEC_W-1:0] hlp_min_vec;
    logic hlp_seen;

    always_comb begin
        hlp_any = |req_eff;
        hlp_max = '0;
        hlp_min_vec = '0;
        hlp_seen = 1'b0;
        for (int v = 0; v < NUM_VEC; v++) begin
            if (req_eff[v] && lvl[v] > hlp_max) begin
                hlp_max = lvl[v];
            end
        end
        for (int v = 0; v < NUM_VEC; v++) begin
            if (req_eff[v] && lvl[v] == hlp_max && !hlp_seen) begin
                hlp_seen = 1'b1;
                hlp_min_vec = VEC_W'(v);
            end
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    chk_level_order: assert property (
        irq_valid_r |-> irq_level_r == $past(hlp_max))
        else $error("Winner is not at the highest pending level.");

    chk_tie_lowest: assert property (
        irq_valid_r |-> irq_vector_r == $past(hlp_min_vec))
        else $error("Winner is not the lowest vector at its level.");

    chk_addr_form: assert property (
        irq_valid_r |-> irq_addr_r == PADDR_W'($past(vector_table_base)
            + PADDR_W'({irq_vector_r, 1'b0})))
        else $error("Vector address is not base plus twice the vector.");

    chk_idle_none: assert property (
        !hlp_any |=> !irq_valid_r && irq_addr_r == RST_ADDR)
        else $error("Request shown with nothing pending.");

    chk_mask_gate: assert property (
        irq_valid_r |-> irq_level_r >= $past(core_mask_level))
        else $error("Winner below the core mask level.");

    chk_fixed_core: assert property (
        irq_valid_r && irq_vector_r inside {[2:5]} |-> irq_level_r == LVL_MAX)
        else $error("Core exception not at level 3.");

    chk_debug_range: assert property (
        irq_valid_r && irq_vector_r inside {6, 7, 9, 10, 11} |-> irq_level_r != 2'h0)
        else $error("Debug source at level 0.");

    chk_periph_range: assert property (
        irq_valid_r && irq_vector_r >= 7'h11 |-> irq_level_r != LVL_MAX)
        else $error("Peripheral source at level 3.");

    chk_ext_sync: assert property (
        $rose(pin_s2_r[0]) && $past(rst_n, 3)
            |-> $past(ext_request_a, 2) && !$past(ext_request_a, 3))
        else $error("External pin A not synchronised in two stages.");

    chk_flash_map: assert property (
        irq_valid_r && irq_vector_r == 7'h16 |-> $past(flash_access_err))
        else $error("Vector 22 shown without flash access error.");

    cov_top_level: cover property (irq_valid_r && irq_level_r == LVL_MAX);
    cov_tie_break: cover property (irq_valid_r && $past($countones(req_eff)) > 1);
    cov_masked: cover property (!irq_valid_r && $past(|req_raw));
    cov_last_vec: cover property (irq_valid_r && irq_vector_r == 7'h49);
endmodule

// [src/ivp_pkg.sv]
package ivp_pkg;
    localparam int NUM_VEC = 74;
    localparam int VEC_W = 7;
    localparam int LVL_W = 2;
    localparam int PADDR_W = 21;
    localparam int ENTRY_WORDS = 2;
    localparam logic [1:0] LVL_MAX = 2'h3;
    localparam logic [1:0] LVL_PERIPH_MAX = 2'h2;
    localparam logic [1:0] LVL_DEBUG_MIN = 2'h1;
    localparam int VEC_ILLEGAL = 2;
    localparam int VEC_SWI3 = 3;
    localparam int VEC_STACK_OVF = 4;
    localparam int VEC_MISALIGN = 5;
    localparam int VEC_DBG_STEP = 6;
    localparam int VEC_DBG_BRKPT = 7;
    localparam int VEC_DBG_TRACE = 9;
    localparam int VEC_DBG_TX = 10;
    localparam int VEC_DBG_RX = 11;
    localparam int VEC_SWI2 = 14;
    localparam int VEC_SWI1 = 15;
    localparam int VEC_SWI0 = 16;
    localparam int VEC_EXT_A = 17;
    localparam int VEC_EXT_B = 18;
    localparam int VEC_LVD = 20;
    localparam int VEC_CLK_SYNTH = 21;
    localparam int VEC_FLASH_ERR = 22;
    localparam int VEC_FLASH_DONE = 23;
    localparam int VEC_FLASH_EMPTY = 24;
    localparam int VEC_CAN_BUS_OFF = 26;
    localparam int VEC_CAN_ERR = 27;
    localparam int VEC_CAN_WAKE = 28;
    localparam int VEC_CAN_MSG = 29;
    localparam int VEC_GPIO_BASE = 30;
    localparam int VEC_SSP1_RX = 38;
    localparam int VEC_SSP1_TX = 39;
    localparam int VEC_SSP0_RX = 40;
    localparam int VEC_SSP0_TX = 41;
    localparam int VEC_ASP1_BASE = 42;
    localparam int VEC_QUAD_DECODER_1_HOME = 47;
    localparam int VEC_QUAD_DECODER_1_INDEX = 48;
    localparam int VEC_QUAD_DECODER_0_HOME = 49;
    localparam int VEC_QUAD_DECODER_0_INDEX = 50;
    localparam int VEC_TIMER_BASE = 52;
    localparam int VEC_ASP0_BASE = 68;
    localparam int VEC_CONV_B = 73;
    localparam int ASP_TX_EMPTY = 0;
    localparam int ASP_TX_IDLE = 1;
    localparam int ASP_RX_ERR = 3;
    localparam int ASP_RX_FULL = 4;
    localparam logic RST_VALID = 1'b0;
    localparam logic [VEC_W-1:0] RST_VEC = 7'h00;
    localparam logic [LVL_W-1:0] RST_LVL = 2'h0;
    localparam logic [PADDR_W-1:0] RST_ADDR = 21'h000000;

    function automatic logic vector_is_used(input int v);
        case (v)
            0, 1, 8, 12, 13, 19, 25, 36, 37, 44, 51, 70: return 1'b0;
            default: return (v >= 0) && (v < NUM_VEC);
        endcase
    endfunction

    function automatic logic [LVL_W-1:0] resolve_level(input int v, input logic [LVL_W-1:0] cfg);
        case (v)
            VEC_ILLEGAL, VEC_SWI3, VEC_STACK_OVF, VEC_MISALIGN: return LVL_MAX;
            VEC_SWI2: return 2'h2;
            VEC_SWI1: return 2'h1;
            VEC_SWI0: return 2'h0;
            VEC_DBG_STEP, VEC_DBG_BRKPT, VEC_DBG_TRACE, VEC_DBG_TX, VEC_DBG_RX:
                return (cfg < LVL_DEBUG_MIN) ? LVL_DEBUG_MIN : cfg;
            default: return (cfg > LVL_PERIPH_MAX) ? LVL_PERIPH_MAX : cfg;
        endcase
    endfunction

    function automatic logic [PADDR_W-1:0] entry_offset(input logic [VEC_W-1:0] v);
        return PADDR_W'(v) * PADDR_W'(ENTRY_WORDS);
    endfunction
endpackage

// [src/vector_arbiter.sv]
`timescale 1ns/1ns
module vector_arbiter
    import ivp_pkg::*;
(
    input wire logic [ivp_pkg::NUM_VEC-1:0] req,
    input wire logic [ivp_pkg::NUM_VEC-1:0][ivp_pkg::LVL_W-1:0] lvl,
    output logic found,
    output logic [ivp_pkg::VEC_W-1:0] win_vec,
    output logic [ivp_pkg::LVL_W-1:0] win_lvl
);
    // Scanning downward, a higher level or an equal level at a lower number takes over.
    always_comb begin
        found = 1'b0;
        win_vec = '0;
        win_lvl = '0;
        for (int v = NUM_VEC - 1; v >= 0; v--) begin
            if (req[v] && (!found || lvl[v] >= win_lvl)) begin
                found = 1'b1;
                win_vec = VEC_W'(v);
                win_lvl = lvl[v];
            end
        end
    end
endmodule

// [tb/req_sources.sv]
`timescale 1ns/1ns
module req_sources
    import ivp_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [ivp_pkg::NUM_VEC-1:0] raise,
    input wire logic irq_valid_r,
    input wire logic [ivp_pkg::VEC_W-1:0] irq_vector_r,
    output logic [ivp_pkg::NUM_VEC-1:0] req
);
    import ivp_pkg::*;
    logic [NUM_VEC-1:0] done;
    assign done = irq_valid_r ? (NUM_VEC'(1) << irq_vector_r) : '0;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            req <= '0;
        end else begin
            req <= (req | raise) & ~done & ~NUM_VEC'(3);
        end
    end
endmodule

// [tb/tb.sv]
`timescale 1ns/1ns
module tb;
    import ivp_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [NUM_VEC-1:0] raise = '0;
    logic [NUM_VEC-1:0] rq;
    logic [NUM_VEC-1:0][LVL_W-1:0] cfg = '0;
    logic [LVL_W-1:0] mask = '0;
    logic [PADDR_W-1:0] base = '0;
    logic vld;
    logic [VEC_W-1:0] vec;
    logic [LVL_W-1:0] lvl;
    logic [PADDR_W-1:0] addr;
    int error_cnt = 0;
    int n_checks = 0;
    always #10 clk = ~clk;
    req_sources req_sources_inst (.clk(clk), .rst_n(rst_n), .raise(raise),
        .irq_valid_r(vld), .irq_vector_r(vec), .req(rq));
    interrupt_vector_priority interrupt_vector_priority_inst (
        .clk(clk), .rst_n(rst_n), .illegal_instr(rq[2]), .swi3(rq[3]),
        .hw_stack_ovf(rq[4]), .misaligned_access(rq[5]), .swi2(rq[14]),
        .swi1(rq[15]), .swi0(rq[16]), .dbg_step(rq[6]), .dbg_brkpt(rq[7]),
        .dbg_trace(rq[9]), .dbg_tx_empty(rq[10]), .dbg_rx_full(rq[11]),
        .ext_request_a(rq[17]), .ext_request_b(rq[18]), .low_voltage_detect(rq[20]),
        .clk_synth_req(rq[21]), .flash_access_err(rq[22]), .flash_cmd_done(rq[23]),
        .flash_buf_empty(rq[24]), .can_bus_off(rq[26]), .can_error(rq[27]),
        .can_wake_up(rq[28]), .can_msg_buf(rq[29]), .gpio_req(rq[35:30]),
        .ssp1_rx_full(rq[38]), .ssp1_tx_empty(rq[39]), .ssp0_rx_full(rq[40]),
        .ssp0_tx_empty(rq[41]), .asp1_tx_empty(rq[42]), .asp1_tx_idle(rq[43]),
        .asp1_rx_err(rq[45]), .asp1_rx_full(rq[46]), .asp0_tx_empty(rq[68]),
        .asp0_tx_idle(rq[69]), .asp0_rx_err(rq[71]), .asp0_rx_full(rq[72]),
        .quad1_home_wdog(rq[47]), .quad1_index(rq[48]), .quad0_home_wdog(rq[49]),
        .quad0_index(rq[50]), .timer_req(rq[67:52]), .converter_b_done(rq[73]),
        .level_cfg(cfg), .core_mask_level(mask), .vector_table_base(base),
        .irq_valid_r(vld), .irq_vector_r(vec), .irq_level_r(lvl), .irq_addr_r(addr));

    task automatic tally_and_finish();
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    function automatic logic [1:0] lvl_of(input int v, input logic [1:0] c);
        if (v >= 2 && v <= 5) return 2'h3;
        if (v >= 14 && v <= 16) return 2'(16 - v);
        if (v inside {6, 7, 9, 10, 11}) return (c == 2'h0) ? 2'h1 : c;
        return (c == 2'h3) ? 2'h2 : c;
    endfunction

    task automatic fire(input logic [NUM_VEC-1:0] m);
        @(posedge clk);
        raise <= m;
        @(posedge clk);
        raise <= '0;
    endtask

    task automatic wait_vld(input logic want);
        for (int i = 0; i < 20 && vld !== want; i++) begin
            @(negedge clk);
        end
        chk(vld, want);
    endtask

    task automatic t_map();
        @(posedge clk);
        base <= 21'h1FFFA0;
        for (int v = 2; v < NUM_VEC; v++) begin
            if (v inside {8, 12, 13, 17, 18, 19, 25, 36, 37, 44, 51, 70}) continue;
            @(posedge clk);
            cfg[v] <= 2'((v + 2) % 4);
            fire(NUM_VEC'(1) << v);
            wait_vld(1'b1);
            chk(vec, v);
            chk(lvl, lvl_of(v, 2'((v + 2) % 4)));
            chk(addr, 21'(base + 21'(2 * v)));
            wait_vld(1'b0);
        end
    endtask

    task automatic t_ext();
        for (int v = 17; v <= 18; v++) begin
            fire(NUM_VEC'(1) << v);
            repeat (3) @(negedge clk);
            chk(vld, 1'b0);
            @(negedge clk);
            chk(vec, v);
            wait_vld(1'b0);
        end
    endtask

    task automatic t_prio();
        logic [VEC_W-1:0] seen[$];
        logic [VEC_W-1:0] last;
        int exp_q[6] = '{2, 6, 30, 40, 22, 16};
        @(posedge clk);
        cfg[6] <= 2'h3;
        cfg[30] <= 2'h2;
        cfg[40] <= 2'h3;
        cfg[22] <= 2'h1;
        cfg[16] <= 2'h3;
        fire(74'h10040410044);
        last = '0;
        repeat (40) begin
            @(negedge clk);
            if (vld === 1'b1 && vec !== last) seen.push_back(vec);
            if (vld === 1'b1) last = vec;
        end
        chk(seen.size(), 6);
        foreach (exp_q[i]) chk(seen[i], exp_q[i]);
    endtask

    task automatic t_mask();
        @(posedge clk);
        mask <= 2'h2;
        cfg[22] <= 2'h1;
        cfg[23] <= 2'h2;
        fire(74'hC00000);
        wait_vld(1'b1);
        chk(vec, 23);
        wait_vld(1'b0);
        repeat (5) @(negedge clk);
        chk(vld, 1'b0);
        chk(rq[22], 1'b1);
        @(posedge clk);
        mask <= 2'h0;
        wait_vld(1'b1);
        chk(vec, 22);
        wait_vld(1'b0);
    endtask

    task automatic t_rst2();
        fire(NUM_VEC'(1) << 2);
        wait_vld(1'b1);
        @(posedge clk);
        rst_n <= 1'b0;
        #1;
        chk({vld, vec, lvl, addr}, 0);
        @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(negedge clk);
        chk(vld, 1'b0);
    endtask

    initial begin
        repeat (8) @(posedge clk);
        chk({vld, vec, lvl, addr}, 0);
        rst_n <= 1'b1;
        t_map();
        t_ext();
        t_prio();
        t_mask();
        t_rst2();
        tally_and_finish();
    end

    initial begin
        #400000;
        error_cnt++;
        tally_and_finish();
    end
endmodule
